//--- inc/sbst_pkg.sv
// Shared constants for the boundary-scan test port and its controller.
// Assumes both ends run on mclk at 250 MHz.
`default_nettype none
package sbst_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TCK_PERIOD_MIN_NS = 50;
  localparam int TCK_HALF_CYC =
    (TCK_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN = 109;
  localparam int OE_CELL = 108;
  localparam int RESET_TMS_EDGES = 5;
  // Value arbitrary, bit 0 set as the identification code marker
  localparam logic [31:0] ID_WORD_DEF = 32'h1234_5001;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // Controller register map, byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TMS = 8'h04;
  localparam logic [7:0] REG_TDI = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_TDO = 8'h10;
  localparam int CMD_NBITS_LSB = 0;
  localparam int CMD_START_BIT = 8;
  localparam int CMD_EN_BIT = 16;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_e;
  typedef enum logic [1:0] {CT_IDLE, CT_LOW, CT_HIGH} sbst_ctl_e;
endpackage
`default_nettype wire

//--- inc/sbst_if.sv
// Test port wires between the scan controller and the device.
// Open inputs read high through the device pull-ups.
`default_nettype none
interface sbst_if;
  logic tck;
  logic tmsOut;
  logic tmsOe;
  logic tdiOut;
  logic tdiOe;
  logic tdoOut;
  logic tdoOe;
  logic tms;
  logic tdi;
  logic tdo;
  // Pull-ups: undriven select and data read as one
  assign tms = tmsOe ? tmsOut : 1'b1;
  assign tdi = tdiOe ? tdiOut : 1'b1;
  // Undriven serial output seen as one by the controller
  assign tdo = tdoOe ? tdoOut : 1'b1;
  modport dev (input tck, input tms, input tdi, output tdoOut,
    output tdoOe);
  modport ctl (output tck, output tmsOut, output tmsOe, output tdiOut,
    output tdiOe, input tdo);
endinterface
`default_nettype wire

//--- src/sbst_tap_dev.sv
// Device end: test access port state machine and scan registers.
// Assumes test clock slower than mclk by several times; pins from
// outside the mclk domain are synchronised before use.
`default_nettype none
module sbst_tap_dev #(
  parameter logic [31:0] ID_WORD = sbst_pkg::ID_WORD_DEF,
  parameter int RING_LEN = sbst_pkg::BSR_LEN
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Test port
  sbst_if.dev tp,
  // Pin ring
  input wire logic [RING_LEN-1:0] ringIn,
  output logic [RING_LEN-1:0] ringOut,
  output logic extestActive,
  output logic qDriveEn
);
  import sbst_pkg::*;

  logic tckS1_r, tckS2_r, tckS3_r;
  logic tmsS1_r, tmsS2_r;
  logic tdiS1_r, tdiS2_r;
  logic tckRise, tckFall;
  sbst_state_e state_r, state_nxt;
  logic [IR_W-1:0] irShift_r;
  logic [IR_W-1:0] ir_r;
  logic bypass_r;
  logic [ID_W-1:0] idShift_r;
  logic [RING_LEN-1:0] bsrShift_r;
  logic [RING_LEN-1:0] bsrUpd_r;
  logic selBsr, selId;
  logic serialBit;
  logic tdoOut_r, tdoOe_r;

  // Two-flop synchronisers; edge detection uses stage two onward
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tckS1_r <= 1'b0;
      tckS2_r <= 1'b0;
      tckS3_r <= 1'b0;
    end else begin
      tckS1_r <= tp.tck;
      tckS2_r <= tckS1_r;
      tckS3_r <= tckS2_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmsS1_r <= 1'b1;
      tmsS2_r <= 1'b1;
      tdiS1_r <= 1'b1;
      tdiS2_r <= 1'b1;
    end else begin
      tmsS1_r <= tp.tms;
      tmsS2_r <= tmsS1_r;
      tdiS1_r <= tp.tdi;
      tdiS2_r <= tdiS1_r;
    end
  end

  assign tckRise = tckS2_r && !tckS3_r;
  assign tckFall = !tckS2_r && tckS3_r;

  // Sixteen-state controller steered by mode select
  always_comb begin
    case (state_r)
      ST_RESET: state_nxt = tmsS2_r ? ST_RESET : ST_IDLE;
      ST_IDLE: state_nxt = tmsS2_r ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = tmsS2_r ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tmsS2_r ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_nxt = tmsS2_r ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tmsS2_r ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_nxt = tmsS2_r ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_nxt = tmsS2_r ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tmsS2_r ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = tmsS2_r ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tmsS2_r ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_nxt = tmsS2_r ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tmsS2_r ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_nxt = tmsS2_r ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_nxt = tmsS2_r ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tmsS2_r ? ST_SEL_DR : ST_IDLE;
      default: state_nxt = ST_RESET;
    endcase
  end

  // Advance only on a test clock rise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else if (tckRise) begin
      state_r <= state_nxt;
    end
  end

  // Register selection; reserved codes fall through to bypass
  always_comb begin
    selBsr = 1'b0;
    selId = 1'b0;
    case (ir_r)
      INS_EXTEST, INS_SAMPLE, INS_SAMPLEZ: selBsr = 1'b1;
      INS_IDCODE: selId = 1'b1;
      INS_BYPASS: selBsr = 1'b0;
      default: selBsr = 1'b0;
    endcase
  end

  // Instruction shift and update
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irShift_r <= IR_CAPTURE;
      ir_r <= INS_IDCODE;
    end else if (tckRise) begin
      case (state_r)
        ST_CAP_IR: irShift_r <= IR_CAPTURE;
        ST_SH_IR: irShift_r <= {tdiS2_r, irShift_r[IR_W-1:1]};
        default: irShift_r <= irShift_r;
      endcase
      // Entering reset loads at once, not one rise later
      if (state_nxt == ST_RESET) begin
        ir_r <= INS_IDCODE;
      end else if (state_r == ST_UPD_IR) begin
        ir_r <= irShift_r;
      end
    end
  end

  // Bypass bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bypass_r <= 1'b0;
    end else if (tckRise && !selBsr && !selId) begin
      if (state_r == ST_CAP_DR) begin
        bypass_r <= 1'b0;
      end else if (state_r == ST_SH_DR) begin
        bypass_r <= tdiS2_r;
      end
    end
  end

  // Identification register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idShift_r <= '0;
    end else if (tckRise && selId) begin
      if (state_r == ST_CAP_DR) begin
        idShift_r <= ID_WORD;
      end else if (state_r == ST_SH_DR) begin
        idShift_r <= {tdiS2_r, idShift_r[ID_W-1:1]};
      end
    end
  end

  // Boundary register: capture pin ring, shift, update latch
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bsrShift_r <= '0;
    end else if (tckRise && selBsr) begin
      if (state_r == ST_CAP_DR) begin
        bsrShift_r <= ringIn;
      end else if (state_r == ST_SH_DR) begin
        bsrShift_r <= {tdiS2_r, bsrShift_r[RING_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bsrUpd_r <= '0;
      bsrUpd_r[OE_CELL] <= 1'b1;
    end else if (tckRise) begin
      if (state_nxt == ST_RESET) begin
        bsrUpd_r[OE_CELL] <= 1'b1;
      end else if (state_r == ST_UPD_DR && selBsr) begin
        bsrUpd_r <= bsrShift_r;
      end
    end
  end

  // Serial output changes on the fall, driven in shift states only
  always_comb begin
    if (state_r == ST_SH_IR) begin
      serialBit = irShift_r[0];
    end else if (selBsr) begin
      serialBit = bsrShift_r[0];
    end else if (selId) begin
      serialBit = idShift_r[0];
    end else begin
      serialBit = bypass_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tdoOut_r <= 1'b0;
      tdoOe_r <= 1'b0;
    end else if (tckFall) begin
      tdoOut_r <= serialBit;
      tdoOe_r <= (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
    end
  end

  assign tp.tdoOut = tdoOut_r;
  assign tp.tdoOe = tdoOe_r;

  // Pin ring control; test reset never touches normal operation
  assign ringOut = bsrUpd_r;
  assign extestActive = (ir_r == INS_EXTEST);
  always_comb begin
    case (ir_r)
      INS_EXTEST: qDriveEn = bsrUpd_r[OE_CELL];
      INS_SAMPLEZ: qDriveEn = 1'b0;
      default: qDriveEn = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

//--- src/sbst_tap_ctl.sv
// Controller end: APB-programmed bit sequencer that drives the test
// clock, mode select and serial input, and records serial output.
// Assumes the device samples on the clock rise and drives on the fall.
`default_nettype none
module sbst_tap_ctl #(
  parameter int TCK_HALF = sbst_pkg::TCK_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Test port
  sbst_if.ctl tp
);
  import sbst_pkg::*;

  logic tdoS1_r, tdoS2_r;
  logic enable_r;
  logic [5:0] nbits_r;
  logic [31:0] tmsSeq_r, tdiSeq_r, tdoCap_r;
  logic [31:0] prdata_r;
  sbst_ctl_e st_r;
  logic [5:0] bitIdx_r;
  logic [7:0] halfCnt_r;
  logic tck_r, tms_r, tdi_r;
  logic wrEn, mapped, startReq, halfDone;

  assign wrEn = psel && penable && pwrite;
  assign mapped = (paddr == REG_CMD) || (paddr == REG_TMS) ||
    (paddr == REG_TDI) || (paddr == REG_STAT) || (paddr == REG_TDO);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;
  assign startReq = wrEn && (paddr == REG_CMD) &&
    pwdata[CMD_START_BIT] && (st_r == CT_IDLE) &&
    pwdata[CMD_EN_BIT];
  assign halfDone = (halfCnt_r == 8'(TCK_HALF - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tdoS1_r <= 1'b1;
      tdoS2_r <= 1'b1;
    end else begin
      tdoS1_r <= tp.tdo;
      tdoS2_r <= tdoS1_r;
    end
  end

  // Register writes; sequence registers frozen while busy
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enable_r <= 1'b0;
      nbits_r <= 6'h00;
      tmsSeq_r <= 32'h0000_0000;
      tdiSeq_r <= 32'h0000_0000;
    end else if (wrEn && st_r == CT_IDLE) begin
      case (paddr)
        REG_CMD: begin
          enable_r <= pwdata[CMD_EN_BIT];
          nbits_r <= pwdata[CMD_NBITS_LSB +: 6];
        end
        REG_TMS: tmsSeq_r <= pwdata;
        REG_TDI: tdiSeq_r <= pwdata;
        default: enable_r <= enable_r;
      endcase
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        REG_CMD: prdata_r <= {15'h0000, enable_r, 10'h000, nbits_r};
        REG_TMS: prdata_r <= tmsSeq_r;
        REG_TDI: prdata_r <= tdiSeq_r;
        REG_STAT: prdata_r <= {31'h0000_0000, st_r != CT_IDLE};
        REG_TDO: prdata_r <= tdoCap_r;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Bit sequencer: low half presents inputs, rise samples output
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= CT_IDLE;
      bitIdx_r <= 6'h00;
      halfCnt_r <= 8'h00;
      tck_r <= 1'b0;
      tms_r <= 1'b1;
      tdi_r <= 1'b1;
      tdoCap_r <= 32'h0000_0000;
    end else begin
      case (st_r)
        CT_IDLE: begin
          tck_r <= 1'b0;
          if (startReq && pwdata[CMD_NBITS_LSB +: 6] != 6'h00) begin
            st_r <= CT_LOW;
            bitIdx_r <= 6'h00;
            halfCnt_r <= 8'h00;
            tms_r <= tmsSeq_r[0];
            tdi_r <= tdiSeq_r[0];
          end
        end
        CT_LOW: begin
          halfCnt_r <= halfDone ? 8'h00 : halfCnt_r + 8'h01;
          if (halfDone) begin
            tck_r <= 1'b1;
            tdoCap_r[bitIdx_r[4:0]] <= tdoS2_r;
            st_r <= CT_HIGH;
          end
        end
        CT_HIGH: begin
          halfCnt_r <= halfDone ? 8'h00 : halfCnt_r + 8'h01;
          if (halfDone) begin
            tck_r <= 1'b0;
            if (bitIdx_r + 6'h01 >= nbits_r || bitIdx_r == 6'h1F) begin
              st_r <= CT_IDLE;
            end else begin
              bitIdx_r <= bitIdx_r + 6'h01;
              tms_r <= tmsSeq_r[bitIdx_r[4:0] + 5'h01];
              tdi_r <= tdiSeq_r[bitIdx_r[4:0] + 5'h01];
              st_r <= CT_LOW;
            end
          end
        end
        default: st_r <= CT_IDLE;
      endcase
    end
  end

  assign tp.tck = tck_r;
  assign tp.tmsOut = tms_r;
  assign tp.tdiOut = tdi_r;
  assign tp.tmsOe = enable_r;
  assign tp.tdiOe = enable_r;
endmodule
`default_nettype wire

//--- dv/sbst_tap_assertions.sv
// Concurrent checks on the test port wires between the two ends.
// Assumes mclk clocks both ends and rst_n is their synchronous reset.
`default_nettype none
module sbst_tap_assertions #(
  parameter int TCK_HALF = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Test port wires
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tmsOe,
  input wire logic tdiOe,
  input wire logic tdoOut,
  input wire logic tdoOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hiLen_r;
  logic [3:0] tmsOnes_r;
  logic tckQ_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Length of the current high half of the test clock
  always_ff @(posedge mclk) begin
    if (!rst_n || !tck) hiLen_r <= 8'h0;
    else hiLen_r <= hiLen_r + 8'h1;
  end
  always_ff @(posedge mclk) tckQ_r <= tck;
  // Run of mode-select ones seen at test clock rises
  always_ff @(posedge mclk) begin
    if (!rst_n || (tck && !tckQ_r && !tms)) tmsOnes_r <= 4'h0;
    else if (tck && !tckQ_r && tmsOnes_r != 4'hF)
      tmsOnes_r <= tmsOnes_r + 4'h1;
  end
  chk_tck_high_len: assert property ($fell(tck) |-> hiLen_r == TCK_HALF)
    else $error("test clock high half has wrong length");
  chk_inputs_at_rise: assert property (
    $rose(tck) |-> $stable(tms) && $stable(tdi))
    else $error("mode select or data moved at clock rise");
  chk_tms_low_change: assert property ($changed(tms) |-> !tck)
    else $error("mode select changed while clock high");
  chk_tdi_low_change: assert property ($changed(tdi) |-> !tck ##1 !tck)
    else $error("serial input changed near clock high");
  chk_tdo_after_fall: assert property (
    $changed(tdoOut) |-> !$past(tck, 1) && !$past(tck, 2))
    else $error("serial output changed outside low half");
  chk_tdo_high_stable: assert property (
    $rose(tck) |=> $stable(tdoOut) [*5])
    else $error("serial output moved during high half");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !tdoOe && !tck && !tmsOe && !tdiOe)
    else $error("port not quiet after reset");
  chk_tms_five_reset: assert property (tmsOnes_r >= 4'h5 |-> !tdoOe)
    else $error("serial output driven after five select ones");
  cover property ($rose(tdoOe));
  cover property (tmsOnes_r == 4'h5);
  cover property ($fell(tck) && tdoOe);
endmodule
`default_nettype wire

//--- dv/sbst_tap_test.sv
// Testbench joining controller and device ends through the interface.
// Assumes APB access to the controller and a 250 MHz mclk.
`default_nettype none
module sbst_tap_test;
  import sbst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [108:0] RING_PAT = {13'h1B2D, 32'hA5C3_0F96,
    32'h3C5A_9617, 32'hD2E1_784B};
  localparam logic [31:0] TDI_W = 32'h7E81_24C3;
  logic mclk = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr;
  logic extestActive, qDriveEn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [BSR_LEN-1:0] ringIn, ringOut;
  int n_fail = 0;
  int compares = 0;
  sbst_if tp();
  sbst_tap_ctl i_sbst_tap_ctl(.mclk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tp(tp));
  sbst_tap_dev i_sbst_tap_dev(.mclk, .rst_n, .tp(tp), .ringIn, .ringOut,
    .extestActive, .qDriveEn);
  sbst_tap_assertions #(.TCK_HALF(TCK_HALF_CYC)) i_sbst_tap_assertions(
    .mclk, .rst_n, .tck(tp.tck), .tms(tp.tms), .tdi(tp.tdi),
    .tmsOe(tp.tmsOe), .tdiOe(tp.tdiOe), .tdoOut(tp.tdoOut),
    .tdoOe(tp.tdoOe));
  always #2 mclk = ~mclk;

  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chkW(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkR(input string what, input logic [108:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // One controller command: nb bits, bit 0 first
  task automatic scan(input int nb, input logic [31:0] tmsW, tdiW,
      output logic [31:0] tdoW);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, REG_TMS, tmsW, q, e);
    apb(1'b1, REG_TDI, tdiW, q, e);
    apb(1'b1, REG_CMD, (32'h1 << CMD_EN_BIT) | (32'h1 << CMD_START_BIT)
      | 32'(nb), q, e);
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      n_fail++;
      close_out();
    end
    apb(1'b0, REG_TDO, 32'h0, tdoW, e);
  endtask

  // From idle: shift nb data bits, then update and back to idle
  task automatic shiftDr(input int nb, input logic [31:0] d,
      output logic [31:0] t);
    logic [31:0] x;
    scan(3, 32'h1, 32'h0, x);
    scan(nb, 32'h1 << (nb - 1), d, t);
    scan(2, 32'h1, 32'h0, x);
  endtask

  task automatic loadIr(input logic [2:0] code);
    logic [31:0] t;
    logic ext0;
    ext0 = extestActive;
    scan(4, 32'h3, 32'h0, t);
    scan(3, 32'h4, 32'(code), t);
    chkW("ir capture", 32'(IR_CAPTURE), {29'h0, t[2:0]});
    chkW("ir before update", 32'(ext0), 32'(extestActive));
    scan(2, 32'h1, 32'h0, t);
    chkW("extest flag", 32'(code == INS_EXTEST), 32'(extestActive));
  endtask

  task automatic testId();
    logic [31:0] t;
    scan(5, 32'h1F, 32'h0, t);
    chkW("extest after reset", 32'h0, 32'(extestActive));
    chkW("drive after reset", 32'h1, 32'(qDriveEn));
    chkW("tdo released", 32'h0, 32'(tp.tdoOe));
    chkW("oe cell after reset", 32'h1, 32'(ringOut[OE_CELL]));
    scan(4, 32'h2, 32'h0, t);
    scan(32, 32'h8000_0000, 32'hFFFF_FFFF, t);
    chkW("id word", ID_WORD_DEF, t);
    scan(2, 32'h1, 32'h0, t);
    $display("test id done");
  endtask

  task automatic testBypass();
    logic [2:0] codes [4];
    logic [31:0] t;
    codes = '{INS_BYPASS, 3'h3, 3'h5, 3'h6};
    for (int i = 0; i < 4; i++) begin
      loadIr(codes[i]);
      shiftDr(8, 32'hB5, t);
      chkW("bypass path", 32'h6A, {24'h0, t[7:0]});
    end
    $display("test bypass done");
  endtask

  task automatic testRing();
    logic [2:0] codes [3];
    logic [31:0] t;
    codes = '{INS_SAMPLEZ, INS_SAMPLE, INS_EXTEST};
    for (int i = 0; i < 3; i++) begin
      loadIr(codes[i]);
      chkW("drive enable", 32'(codes[i] == INS_SAMPLE), 32'(qDriveEn));
      shiftDr(32, TDI_W, t);
      chkW("ring capture", RING_PAT[31:0], t);
      chkR("ring update", {TDI_W, RING_PAT[108:32]}, ringOut);
    end
    $display("test ring done");
  endtask

  // Five ones from inside a data shift must reach reset at once
  task automatic testDeepReset();
    logic [31:0] t;
    loadIr(INS_EXTEST);
    scan(3, 32'h1, 32'h0, t);
    scan(5, 32'h1F, 32'h0, t);
    chkW("ir after deep reset", 32'h0, 32'(extestActive));
    chkW("drive after deep reset", 32'h1, 32'(qDriveEn));
    $display("test deep reset done");
  endtask

  task automatic testApb();
    logic [31:0] q;
    logic e;
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, q, e);
    chkW("unmapped write error", 32'h1, 32'(e));
    apb(1'b0, 8'hFC, 32'h0, q, e);
    chkW("unmapped read error", 32'h1, 32'(e));
    chkW("unmapped read data", 32'h0, q);
    apb(1'b1, REG_STAT, 32'hFFFF_FFFF, q, e);
    apb(1'b0, REG_STAT, 32'h0, q, e);
    chkW("status read only", 32'h0, q);
    $display("test apb done");
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ringIn = RING_PAT;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    testId();
    testBypass();
    testRing();
    testId();
    testDeepReset();
    testApb();
    close_out();
  end
endmodule
`default_nettype wire
